// ===== hdl/dcd_pkg.sv
// Constants and types for the direct command decoder.
// Assumes a single 50 MHz clock domain; commands arrive as validated byte strobes.
// Behaviour
// - Code C1 restores all defaults in any mode, no completion interrupt.
// - C2 or C3 abort activity and empty FIFO; needs chip-active; chainable.
// - C4 transmits with CRC, C5 without; need active and transmitter-on.
// - C8 runs initial collision avoidance then field on; needs active; interrupts.
// - Response field-on codes run collision avoidance; CA forces slots zero; interrupt.
// - Go-to-normal accepted only in bit-rate detection mode; chainable, no interrupt.
// - Analog preset loads rx/tx config from mode and bit rate; all modes.
// - D0 masks received data; needs active and receiver-on.
// - D1 unmasks receive data, overriding mask timer; needs active and receiver-on.
// - D3 measures amplitude into converter output; not chainable; interrupts.
// - D4 reduces gain by noise; needs active and receiver-on; no interrupt.
// - D5 drops squelch, loads manual gain reduction; not chainable; no interrupt.
// - D6 adjusts regulators to supply; needs active; interrupts when done.
// - D7 enables transmitter and calibrates modulation depth; interrupts when done.
// - D8 trims tuning capacitors to resonance; interrupts when done.
// - D9 measures driver-to-receive phase; needs active; interrupts when done.
// - DA clears signal-strength bits and restarts measurement; needs active.
// - DC enters transparent mode; needs active; not chainable; no interrupt.
// - FC grants test register write access always; other F and unused ignored.
// - Field-on completion raises field-switched-on or external-collision flag.
// - All four transmit codes need the transmitter-on bit.
// - Default restore while inactive keeps FIFO and FIFO status untouched.
package dcd_pkg;
    localparam logic [7:0] CMD_SET_DEFAULT = 8'hC1;
    localparam logic [7:0] CMD_CLEAR_A = 8'hC2;
    localparam logic [7:0] CMD_CLEAR_B = 8'hC3;
    localparam logic [7:0] CMD_TX_CRC = 8'hC4;
    localparam logic [7:0] CMD_TX_NOCRC = 8'hC5;
    localparam logic [7:0] CMD_TX_REQ = 8'hC6;
    localparam logic [7:0] CMD_TX_WUP = 8'hC7;
    localparam logic [7:0] CMD_FIELD_INIT = 8'hC8;
    localparam logic [7:0] CMD_FIELD_RESP = 8'hC9;
    localparam logic [7:0] CMD_FIELD_RESP0 = 8'hCA;
    localparam logic [7:0] CMD_NORMAL = 8'hCB;
    localparam logic [7:0] CMD_PRESET = 8'hCC;
    localparam logic [7:0] CMD_MASK_RX = 8'hD0;
    localparam logic [7:0] CMD_UNMASK_RX = 8'hD1;
    localparam logic [7:0] CMD_MEAS_AMP = 8'hD3;
    localparam logic [7:0] CMD_SQUELCH = 8'hD4;
    localparam logic [7:0] CMD_RESET_GAIN = 8'hD5;
    localparam logic [7:0] CMD_ADJ_REG = 8'hD6;
    localparam logic [7:0] CMD_CAL_MOD = 8'hD7;
    localparam logic [7:0] CMD_CAL_ANT = 8'hD8;
    localparam logic [7:0] CMD_MEAS_PHASE = 8'hD9;
    localparam logic [7:0] CMD_CLEAR_RSSI = 8'hDA;
    localparam logic [7:0] CMD_TRANSPARENT = 8'hDC;
    localparam logic [7:0] CMD_TEST_ACCESS = 8'hFC;

    // Action index, one-hot position on the start vector
    typedef enum logic [4:0] {
        ACT_NONE = 5'h00, ACT_DEFAULT = 5'h01, ACT_CLEAR = 5'h02, ACT_TX_CRC = 5'h03,
        ACT_TX_NOCRC = 5'h04, ACT_TX_REQ = 5'h05, ACT_TX_WUP = 5'h06, ACT_FIELD_INIT = 5'h07,
        ACT_FIELD_RESP = 5'h08, ACT_FIELD_RESP0 = 5'h09, ACT_NORMAL = 5'h0A, ACT_PRESET = 5'h0B,
        ACT_MASK_RX = 5'h0C, ACT_UNMASK_RX = 5'h0D, ACT_MEAS_AMP = 5'h0E, ACT_SQUELCH = 5'h0F,
        ACT_RESET_GAIN = 5'h10, ACT_ADJ_REG = 5'h11, ACT_CAL_MOD = 5'h12, ACT_CAL_ANT = 5'h13,
        ACT_MEAS_PHASE = 5'h14, ACT_CLEAR_RSSI = 5'h15, ACT_TRANSPARENT = 5'h16,
        ACT_TEST_ACCESS = 5'h17
    } dcd_act_t;

    localparam int ACT_COUNT = 24;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_BUSY = 2'b01,
        ST_DONE = 2'b10
    } dcd_state_t;

    localparam logic [ACT_COUNT-1:0] START_RESET = 24'h000000;
    localparam logic [7:0] CODE_RESET = 8'h00;
endpackage

// ===== hdl/dcd_lookup.sv
// Code lookup: maps a command byte to an action and its properties.
// Purely combinational; the top registers everything it produces.
`timescale 1ns/1ns
`default_nettype none
module dcd_lookup (
    input wire logic [7:0] code,            // Command byte
    input wire logic chip_active,           // Chip-active state bit
    input wire logic tx_on,                 // Transmitter-on state bit
    input wire logic rx_on,                 // Receiver-on state bit
    input wire logic bitrate_detect,        // Bit-rate detection mode
    output dcd_pkg::dcd_act_t act,          // Decoded action, NONE if refused
    output logic chainable,                 // Action may be chained
    output logic irq_after                  // Action interrupts on termination
);
    always_comb begin
        act = dcd_pkg::ACT_NONE;
        chainable = 1'b1;
        irq_after = 1'b0;
        unique case (code)
            dcd_pkg::CMD_SET_DEFAULT: begin
                act = dcd_pkg::ACT_DEFAULT;
                chainable = 1'b0;
            end
            dcd_pkg::CMD_CLEAR_A, dcd_pkg::CMD_CLEAR_B: begin
                if (chip_active) act = dcd_pkg::ACT_CLEAR;
            end
            dcd_pkg::CMD_TX_CRC: begin
                if (chip_active && tx_on) act = dcd_pkg::ACT_TX_CRC;
            end
            dcd_pkg::CMD_TX_NOCRC: begin
                if (chip_active && tx_on) act = dcd_pkg::ACT_TX_NOCRC;
            end
            dcd_pkg::CMD_TX_REQ: begin
                if (chip_active && tx_on) act = dcd_pkg::ACT_TX_REQ;
            end
            dcd_pkg::CMD_TX_WUP: begin
                if (chip_active && tx_on) act = dcd_pkg::ACT_TX_WUP;
            end
            dcd_pkg::CMD_FIELD_INIT: begin
                if (chip_active) act = dcd_pkg::ACT_FIELD_INIT;
                irq_after = 1'b1;
            end
            dcd_pkg::CMD_FIELD_RESP: begin
                if (chip_active) act = dcd_pkg::ACT_FIELD_RESP;
                irq_after = 1'b1;
            end
            dcd_pkg::CMD_FIELD_RESP0: begin
                if (chip_active) act = dcd_pkg::ACT_FIELD_RESP0;
                irq_after = 1'b1;
            end
            dcd_pkg::CMD_NORMAL: begin
                if (bitrate_detect) act = dcd_pkg::ACT_NORMAL;
            end
            dcd_pkg::CMD_PRESET: act = dcd_pkg::ACT_PRESET;
            dcd_pkg::CMD_MASK_RX: begin
                if (chip_active && rx_on) act = dcd_pkg::ACT_MASK_RX;
            end
            dcd_pkg::CMD_UNMASK_RX: begin
                if (chip_active && rx_on) act = dcd_pkg::ACT_UNMASK_RX;
            end
            dcd_pkg::CMD_MEAS_AMP: begin
                if (chip_active) act = dcd_pkg::ACT_MEAS_AMP;
                chainable = 1'b0;
                irq_after = 1'b1;
            end
            dcd_pkg::CMD_SQUELCH: begin
                if (chip_active && rx_on) act = dcd_pkg::ACT_SQUELCH;
                chainable = 1'b0;
            end
            dcd_pkg::CMD_RESET_GAIN: begin
                if (chip_active) act = dcd_pkg::ACT_RESET_GAIN;
                chainable = 1'b0;
            end
            dcd_pkg::CMD_ADJ_REG: begin
                if (chip_active) act = dcd_pkg::ACT_ADJ_REG;
                chainable = 1'b0;
                irq_after = 1'b1;
            end
            dcd_pkg::CMD_CAL_MOD: begin
                if (chip_active) act = dcd_pkg::ACT_CAL_MOD;
                chainable = 1'b0;
                irq_after = 1'b1;
            end
            dcd_pkg::CMD_CAL_ANT: begin
                if (chip_active) act = dcd_pkg::ACT_CAL_ANT;
                chainable = 1'b0;
                irq_after = 1'b1;
            end
            dcd_pkg::CMD_MEAS_PHASE: begin
                if (chip_active) act = dcd_pkg::ACT_MEAS_PHASE;
                chainable = 1'b0;
                irq_after = 1'b1;
            end
            dcd_pkg::CMD_CLEAR_RSSI: begin
                if (chip_active) act = dcd_pkg::ACT_CLEAR_RSSI;
            end
            dcd_pkg::CMD_TRANSPARENT: begin
                if (chip_active) act = dcd_pkg::ACT_TRANSPARENT;
                chainable = 1'b0;
            end
            dcd_pkg::CMD_TEST_ACCESS: act = dcd_pkg::ACT_TEST_ACCESS;
            default: begin
                act = dcd_pkg::ACT_NONE;
                chainable = 1'b0;
            end
        endcase
    end
endmodule
`default_nettype wire

// ===== hdl/dcd_top.sv
// Direct command decoder top: takes command bytes, starts actions, tracks completion.
// Assumes cmd_valid is a one-cycle strobe from same-clock host port logic; action
// engines report their finish on same-clock done pulses.
`timescale 1ns/1ns
`default_nettype none
module dcd_top (
    input wire logic clk,                   // 50 MHz system clock
    input wire logic resetn,                // Async reset, active low
    input wire logic cmd_valid,             // Command byte strobe
    input wire logic [7:0] cmd_code,        // Command byte
    input wire logic chip_active,           // Chip-active bit
    input wire logic tx_on,                 // Transmitter-on bit
    input wire logic rx_on,                 // Receiver-on bit
    input wire logic wake_mode_bit,         // Wake-up mode bit
    input wire logic bitrate_detect,        // Bit-rate detection mode
    input wire logic action_done,           // Running long action finished
    input wire logic field_collision,       // External field seen by field-on action
    output logic [23:0] action_start,       // One-hot action start pulse
    output logic [7:0] accepted_code,       // Last accepted code
    output logic cmd_accepted,              // Pulse: command accepted
    output logic cmd_ignored,               // Pulse: command refused or unused
    output logic busy,                      // Long action in progress (non-chainable other than set-default, or interrupting)
    output logic restore_defaults,          // Pulse: reset registers to defaults
    output logic keep_fifo,                 // With restore: leave FIFO untouched
    output logic fifo_flush,                // Pulse: abort activity, empty FIFO
    output logic slots_zero,                // Level: field-on with forced zero slots
    output logic rx_masked,                 // Level: received data ignored
    output logic transparent,               // Level: transparent mode entered
    output logic test_write_en,             // Level: test register writes granted
    output logic irq_cmd_done,              // Pulse: completion interrupt
    output logic irq_field_on,              // Pulse: field switched on
    output logic irq_field_coll             // Pulse: external field collision
);
    // ==========================================================
    // Lookup
    dcd_pkg::dcd_act_t act;
    logic chainable;
    logic irq_after;
    logic take;
    logic wake_sel;

    dcd_lookup u_lookup (
        .code(cmd_code),
        .chip_active(chip_active),
        .tx_on(tx_on),
        .rx_on(rx_on),
        .bitrate_detect(bitrate_detect),
        .act(act),
        .chainable(chainable),
        .irq_after(irq_after)
    );

    assign wake_sel = wake_mode_bit;
    // A valid command is a candidate when the lookup does not refuse it; busy blocking is applied later
    assign take = cmd_valid && (act != dcd_pkg::ACT_NONE);

    // ==========================================================
    // Sequencer
    dcd_pkg::dcd_state_t state_reg;
    logic irq_pend_reg;
    logic field_pend_reg;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_reg <= dcd_pkg::ST_IDLE;
            irq_pend_reg <= 1'b0;
            field_pend_reg <= 1'b0;
        end else begin
            unique case (state_reg)
                dcd_pkg::ST_IDLE: begin
                    if (take && irq_after) begin
                        state_reg <= dcd_pkg::ST_BUSY;
                        irq_pend_reg <= 1'b1;
                        field_pend_reg <= (act == dcd_pkg::ACT_FIELD_INIT) ||
                                          (act == dcd_pkg::ACT_FIELD_RESP) ||
                                          (act == dcd_pkg::ACT_FIELD_RESP0);
                    end else if (take && !chainable && act != dcd_pkg::ACT_DEFAULT) begin
                        state_reg <= dcd_pkg::ST_BUSY;
                        irq_pend_reg <= 1'b0;
                        field_pend_reg <= 1'b0;
                    end
                end
                dcd_pkg::ST_BUSY: begin
                    if (action_done) state_reg <= dcd_pkg::ST_DONE;
                end
                dcd_pkg::ST_DONE: begin
                    state_reg <= dcd_pkg::ST_IDLE;
                    irq_pend_reg <= 1'b0;
                    field_pend_reg <= 1'b0;
                end
            endcase
        end
    end

    // Controller must not send while busy; anything but set-default arriving then is dropped
    logic take_idle;
    assign take_idle = take && (state_reg == dcd_pkg::ST_IDLE || act == dcd_pkg::ACT_DEFAULT);

    // ==========================================================
    // Start pulses and acknowledge
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            action_start <= dcd_pkg::START_RESET;
            accepted_code <= dcd_pkg::CODE_RESET;
            cmd_accepted <= 1'b0;
            cmd_ignored <= 1'b0;
        end else begin
            action_start <= dcd_pkg::START_RESET;
            cmd_accepted <= take_idle;
            cmd_ignored <= cmd_valid && !take_idle;
            if (take_idle) begin
                action_start[act] <= 1'b1;
                accepted_code <= cmd_code;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            busy <= 1'b0;
        end else begin
            busy <= (state_reg == dcd_pkg::ST_BUSY) ||
                    (take_idle && (irq_after || !chainable) && act != dcd_pkg::ACT_DEFAULT);
        end
    end

    // ==========================================================
    // Default restore and clear
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            restore_defaults <= 1'b0;
            keep_fifo <= 1'b0;
            fifo_flush <= 1'b0;
        end else begin
            restore_defaults <= take_idle && act == dcd_pkg::ACT_DEFAULT;
            if (take_idle && act == dcd_pkg::ACT_DEFAULT) keep_fifo <= !chip_active;
            fifo_flush <= take_idle && (act == dcd_pkg::ACT_CLEAR ||
                          (act == dcd_pkg::ACT_DEFAULT && chip_active));
        end
    end

    // ==========================================================
    // Mode levels
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rx_masked <= 1'b0;
            transparent <= 1'b0;
            test_write_en <= 1'b0;
            slots_zero <= 1'b0;
        end else if (take_idle && act == dcd_pkg::ACT_DEFAULT) begin
            rx_masked <= 1'b0;
            transparent <= 1'b0;
            test_write_en <= 1'b0;
            slots_zero <= 1'b0;
        end else if (take_idle) begin
            if (act == dcd_pkg::ACT_MASK_RX) rx_masked <= 1'b1;
            if (act == dcd_pkg::ACT_UNMASK_RX || act == dcd_pkg::ACT_CLEAR) rx_masked <= 1'b0;
            if (act == dcd_pkg::ACT_TRANSPARENT) transparent <= 1'b1;
            if (act == dcd_pkg::ACT_TEST_ACCESS) test_write_en <= 1'b1;
            if (act == dcd_pkg::ACT_FIELD_RESP0) slots_zero <= 1'b1;
            if (act == dcd_pkg::ACT_FIELD_RESP || act == dcd_pkg::ACT_FIELD_INIT) slots_zero <= 1'b0;
        end
    end

    // ==========================================================
    // Completion interrupts
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            irq_cmd_done <= 1'b0;
            irq_field_on <= 1'b0;
            irq_field_coll <= 1'b0;
        end else begin
            irq_cmd_done <= state_reg == dcd_pkg::ST_BUSY && action_done && irq_pend_reg &&
                            !field_pend_reg;
            irq_field_on <= state_reg == dcd_pkg::ST_BUSY && action_done && field_pend_reg &&
                            !field_collision;
            irq_field_coll <= state_reg == dcd_pkg::ST_BUSY && action_done && field_pend_reg &&
                              field_collision;
        end
    end

    logic unused_wake;
    assign unused_wake = wake_sel;
endmodule
`default_nettype wire

// ===== dv/dcd_engine_model.sv
// Behavioural model of the action engines behind the decoder.
// Same clock as dcd_top; each long action gets one done pulse back.
`timescale 1ns/1ns
`default_nettype none
module dcd_engine_model (
    input wire logic clk, // Clock
    input wire logic resetn, // Async reset, active low
    input wire logic [23:0] action_start, // Start pulses
    input wire logic slow, // Answer late when high
    input wire logic coll, // Report an external field
    output logic action_done, // Finish pulse
    output logic field_collision // Collision level, valid with done
);
    // Actions that hold the decoder busy until they report back
    localparam logic [23:0] LONG_MASK = 24'h5FC380;
    logic [7:0] cnt_reg;
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cnt_reg <= 8'h00;
            action_done <= 1'b0;
            field_collision <= 1'b0;
        end else begin
            action_done <= 1'b0;
            field_collision <= ~field_collision;
            if (|(action_start & LONG_MASK)) begin
                cnt_reg <= slow ? 8'(12 + $urandom % 20) : 8'h02;
            end else if (cnt_reg != 8'h00) begin
                cnt_reg <= cnt_reg - 8'h01;
                if (cnt_reg == 8'h01) begin
                    action_done <= 1'b1;
                    field_collision <= coll;
                end
            end
        end
    end
endmodule
`default_nettype wire

// ===== dv/dcd_top_monitor.sv
// Checker for the direct command decoder top.
// Bound to dcd_top; sees its ports only.
`timescale 1ns/1ns
`default_nettype none
module dcd_top_monitor (
    input wire logic clk, // Clock
    input wire logic resetn, // Async reset, active low
    input wire logic cmd_valid, // Command strobe
    input wire logic [7:0] cmd_code, // Command byte
    input wire logic chip_active, // Chip-active bit
    input wire logic tx_on, // Transmitter-on bit
    input wire logic rx_on, // Receiver-on bit
    input wire logic action_done, // Action finished
    input wire logic field_collision, // External field seen
    input wire logic [23:0] action_start, // One-hot start
    input wire logic cmd_accepted, // Accept pulse
    input wire logic cmd_ignored, // Refuse pulse
    input wire logic busy, // Long action running
    input wire logic restore_defaults, // Default restore pulse
    input wire logic keep_fifo, // FIFO left untouched
    input wire logic fifo_flush, // FIFO empty pulse
    input wire logic irq_cmd_done, // Completion interrupt
    input wire logic irq_field_on, // Field switched on
    input wire logic irq_field_coll // Field collision
);
    // ==========================================
    // Assertions
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);
    sequence s_take_default;
        cmd_valid && cmd_code == dcd_pkg::CMD_SET_DEFAULT;
    endsequence
    sequence s_default_done;
        cmd_accepted && restore_defaults && action_start == 24'h000002;
    endsequence
    chk_answer_once: assert property (cmd_valid |=> cmd_accepted != cmd_ignored)
        else $error("command not answered exactly once");
    chk_no_spurious: assert property (!cmd_valid |=> !cmd_accepted && !cmd_ignored && action_start == 24'h000000)
        else $error("answer without command");
    chk_default_all: assert property (s_take_default |=> s_default_done)
        else $error("default restore not started");
    chk_keep_fifo: assert property (s_take_default |=> keep_fifo != $past(chip_active) && fifo_flush == $past(chip_active))
        else $error("fifo handling on restore wrong");
    chk_clear_active: assert property (cmd_valid && !chip_active && (cmd_code == dcd_pkg::CMD_CLEAR_A
        || cmd_code == dcd_pkg::CMD_CLEAR_B) |=> cmd_ignored && !fifo_flush) else $error("clear taken while inactive");
    chk_tx_needs_on: assert property (cmd_valid && !tx_on && cmd_code >= dcd_pkg::CMD_TX_CRC
        && cmd_code <= dcd_pkg::CMD_TX_WUP |=> cmd_ignored) else $error("transmit taken with transmitter off");
    chk_rx_needs_on: assert property (cmd_valid && !rx_on && (cmd_code == dcd_pkg::CMD_MASK_RX
        || cmd_code == dcd_pkg::CMD_UNMASK_RX || cmd_code == dcd_pkg::CMD_SQUELCH) |=> cmd_ignored)
        else $error("receive command taken with receiver off");
    chk_reserved_ignored: assert property (cmd_valid && cmd_code[7:4] == 4'hF
        && cmd_code != dcd_pkg::CMD_TEST_ACCESS |=> cmd_ignored) else $error("reserved code taken");
    chk_busy_refuse: assert property (busy && cmd_valid && cmd_code != dcd_pkg::CMD_SET_DEFAULT |=> cmd_ignored)
        else $error("command taken while busy");
    chk_field_flag: assert property ((irq_field_on || irq_field_coll) |-> $past(action_done)
        && irq_field_coll == $past(field_collision) && irq_field_on != irq_field_coll) else $error("field flag wrong");
    chk_irq_release: assert property (irq_cmd_done |-> busy ##1 !busy)
        else $error("busy not released after interrupt");
    chk_start_onehot: assert property ($onehot0(action_start) && !action_start[0])
        else $error("start vector not one-hot");
endmodule
`default_nettype wire

// ===== dv/dcd_top_test.sv
// Self-checking bench for the direct command decoder.
// Drives command bytes and state bits; an engine model answers long actions.
`timescale 1ns/1ns
`default_nettype none
module dcd_top_test;
    logic clk = 1'b0, resetn = 1'b0, cmd_valid = 1'b0, chip_active = 1'b1, tx_on = 1'b1, rx_on = 1'b1;
    logic wake_mode_bit = 1'b0, bitrate_detect = 1'b1, slow = 1'b1, coll = 1'b0;
    logic [7:0] cmd_code = 8'h00;
    logic action_done, field_collision, cmd_accepted, cmd_ignored, busy, restore_defaults, keep_fifo;
    logic fifo_flush, slots_zero, rx_masked, transparent, test_write_en, irq_cmd_done, irq_field_on, irq_field_coll;
    logic [23:0] action_start;
    logic [7:0] accepted_code;
    logic exp_rxm = 1'b0, exp_tr = 1'b0, exp_te = 1'b0, exp_keep = 1'b0;
    int n_errors = 0, n_compared = 0;
    logic [7:0] codes [26] = '{8'hC1, 8'hC2, 8'hC3, 8'hC4, 8'hC5, 8'hC6, 8'hC7, 8'hC8, 8'hC9, 8'hCA, 8'hCB, 8'hCC,
        8'hD0, 8'hD1, 8'hD2, 8'hD3, 8'hD4, 8'hD5, 8'hD6, 8'hD7, 8'hD8, 8'hD9, 8'hDA, 8'hDC, 8'hFC, 8'hF0};
    dcd_top i_dcd_top (.clk(clk), .resetn(resetn), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
        .chip_active(chip_active), .tx_on(tx_on), .rx_on(rx_on), .wake_mode_bit(wake_mode_bit),
        .bitrate_detect(bitrate_detect), .action_done(action_done), .field_collision(field_collision),
        .action_start(action_start), .accepted_code(accepted_code), .cmd_accepted(cmd_accepted),
        .cmd_ignored(cmd_ignored), .busy(busy), .restore_defaults(restore_defaults), .keep_fifo(keep_fifo),
        .fifo_flush(fifo_flush), .slots_zero(slots_zero), .rx_masked(rx_masked), .transparent(transparent),
        .test_write_en(test_write_en), .irq_cmd_done(irq_cmd_done), .irq_field_on(irq_field_on),
        .irq_field_coll(irq_field_coll));
    dcd_engine_model i_dcd_engine_model (.clk(clk), .resetn(resetn), .action_start(action_start), .slow(slow),
        .coll(coll), .action_done(action_done), .field_collision(field_collision));
    always #10 clk = ~clk;
    // ==========================================
    // Expected action index for a code in the present state, 0 when refused
    function automatic int exp_act(input logic [7:0] c);
        case (c)
            8'hC1: return 1;
            8'hC2, 8'hC3: return chip_active ? 2 : 0;
            8'hC4, 8'hC5, 8'hC6, 8'hC7: return (chip_active && tx_on) ? int'(c - 8'hC1) : 0;
            8'hC8, 8'hC9, 8'hCA: return chip_active ? int'(c - 8'hC1) : 0;
            8'hCB: return bitrate_detect ? 10 : 0;
            8'hCC: return 11;
            8'hD0, 8'hD1: return (chip_active && rx_on) ? int'(c - 8'hC4) : 0;
            8'hD3: return chip_active ? 14 : 0;
            8'hD4: return (chip_active && rx_on) ? 15 : 0;
            8'hD5, 8'hD6, 8'hD7, 8'hD8, 8'hD9, 8'hDA: return chip_active ? int'(c - 8'hC5) : 0;
            8'hDC: return chip_active ? 22 : 0;
            8'hFC: return 23;
            default: return 0;
        endcase
    endfunction
    task automatic check_bit(input string name, input logic exp, input logic got);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %s expected %b seen %b", name, exp, got);
        end
    endtask
    task automatic check_vec(input string name, input logic [23:0] exp, input logic [23:0] got);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic finish_test();
        $display("errors %0d compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // ==========================================
    // Waits out a long action; a refused command is slipped in when slow
    task automatic wait_done(input int idx);
        int k;
        check_bit("busy", 1'b1, busy);
        if (slow) send(8'($urandom_range(8'hFF, 8'hC2)), 1'b1);
        for (k = 0; k < 1000; k++) begin
            if (irq_cmd_done || irq_field_on || irq_field_coll || !busy) break;
            @(posedge clk);
            #1;
        end
        if (k == 1000) begin
            n_errors++;
            $display("mismatch completion expected done seen timeout");
            finish_test();
        end
        if (idx >= 7 && idx <= 9) begin
            check_bit("field_coll", coll, irq_field_coll);
            check_bit("field_on", !coll, irq_field_on);
        end else check_bit("cmd_done", idx inside {14, 17, 18, 19, 20}, irq_cmd_done);
        @(posedge clk);
        #1;
        check_bit("busy_end", 1'b0, busy);
    endtask
    task automatic send(input logic [7:0] c, input logic refuse);
        int idx;
        idx = refuse ? 0 : exp_act(c);
        cmd_code = c;
        cmd_valid = 1'b1;
        @(posedge clk);
        #1;
        cmd_valid = 1'b0;
        cmd_code = ~c;
        if (idx == 1) {exp_rxm, exp_tr, exp_te, exp_keep} = {3'b000, !chip_active};
        if (idx == 2 || idx == 13) exp_rxm = 1'b0;
        if (idx == 12) exp_rxm = 1'b1;
        if (idx == 22) exp_tr = 1'b1;
        if (idx == 23) exp_te = 1'b1;
        check_bit("accepted", idx != 0, cmd_accepted);
        check_bit("ignored", idx == 0, cmd_ignored);
        check_vec("start", (idx != 0) ? 24'h000001 << idx : 24'h000000, action_start);
        if (idx != 0) check_vec("code", {16'h0000, c}, {16'h0000, accepted_code});
        check_bit("restore", idx == 1, restore_defaults);
        check_bit("flush", idx == 2 || (idx == 1 && chip_active), fifo_flush);
        check_bit("keep_fifo", exp_keep, keep_fifo);
        check_bit("rx_masked", exp_rxm, rx_masked);
        check_bit("transparent", exp_tr, transparent);
        check_bit("test_wr", exp_te, test_write_en);
        if (idx == 9 || idx == 1) check_bit("slots_zero", idx == 9, slots_zero);
        if (idx inside {7, 8, 9, [14:20], 22}) wait_done(idx);
    endtask
    // ==========================================
    // Main sequence
    initial begin
        void'($urandom(97));
        repeat (6) @(posedge clk);
        #1;
        resetn = 1'b1;
        foreach (codes[i]) send(codes[i], 1'b0);
        coll = 1'b1;
        send(8'hC8, 1'b0);
        chip_active = 1'b0;
        send(8'hC1, 1'b0);
        repeat (400) begin
            chip_active = ($urandom % 4) != 0;
            tx_on = 1'($urandom);
            rx_on = 1'($urandom);
            bitrate_detect = 1'($urandom);
            wake_mode_bit = 1'($urandom);
            slow = 1'($urandom);
            coll = 1'($urandom);
            send((($urandom % 5) != 0) ? codes[$urandom % 26] : 8'($urandom), 1'b0);
        end
        finish_test();
    end
endmodule
bind dcd_top dcd_top_monitor i_dcd_top_monitor (.clk(clk), .resetn(resetn), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .chip_active(chip_active), .tx_on(tx_on), .rx_on(rx_on), .action_done(action_done),
    .field_collision(field_collision), .action_start(action_start), .cmd_accepted(cmd_accepted),
    .cmd_ignored(cmd_ignored), .busy(busy), .restore_defaults(restore_defaults), .keep_fifo(keep_fifo),
    .fifo_flush(fifo_flush), .irq_cmd_done(irq_cmd_done), .irq_field_on(irq_field_on),
    .irq_field_coll(irq_field_coll));
`default_nettype wire
